// *** dv/test_tsrmux_top.sv ***
// Self-checking bench of the test signal and role mux control
`timescale 1ns/1ps
module test_tsrmux_top;
	import tsrmux_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic sync_clock_output, port_a_pin1_i, sync_clock_input, sync_external;
	tsrmux_test_src_t test_src;
	tsrmux_pin_t gpio_pa0, gpio_pa1, gpio_pb1, port_a_pin0, port_a_pin1, port_b_pin1;
	tsrmux_analog_t analog_ctl;
	int num_errors = 0;
	int check_count = 0;
	tsrmux_top uut (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.test_src(test_src),
		.gpio_pa0(gpio_pa0),
		.gpio_pa1(gpio_pa1),
		.gpio_pb1(gpio_pb1),
		.sync_clock_output(sync_clock_output),
		.port_a_pin1_i(port_a_pin1_i),
		.port_a_pin0(port_a_pin0),
		.port_a_pin1(port_a_pin1),
		.port_b_pin1(port_b_pin1),
		.analog_ctl(analog_ctl),
		.sync_clock_input(sync_clock_input),
		.sync_external(sync_external)
	);
	// 250 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run
	// Bounds every wait so a silent slave cannot hang the run
	task automatic lim(inout int n);
		n++;
		if (n > 60) begin
			num_errors++;
			complete_run;
		end
	endtask : lim
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = TSRMUX_RESP_OKAY);
		int n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			lim(n);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		chk("bresp", s_axi_bresp, er);
		s_axi_bready <= 1'b0;
		// One idle edge so a following call never re-raises bready in this step
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] ed, input logic [1:0] er = TSRMUX_RESP_OKAY);
		int n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			lim(n);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rdata", s_axi_rdata, {24'h0, ed});
		chk("rresp", s_axi_rresp, er);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset;
		rd(TSRMUX_OFF_TEST, 8'h00);
		rd(TSRMUX_OFF_ROLE, 8'h00);
		chk("analog", analog_ctl, '0);
		chk("pin0", port_a_pin0, gpio_pa0);
		wr(TSRMUX_OFF_STAT, 8'hFF);
		rd(TSRMUX_OFF_STAT, 8'h04);
		// Unmapped address answers SLVERR; lane 0 strobe low drops the write
		wr(4'h2, 8'hFF, TSRMUX_RESP_SLVERR);
		rd(4'h2, 8'h00, TSRMUX_RESP_SLVERR);
		s_axi_wstrb <= 4'hE;
		wr(TSRMUX_OFF_TEST, 8'hFF);
		s_axi_wstrb <= 4'hF;
		rd(TSRMUX_OFF_TEST, 8'h00);
	endtask : t_reset
	// Analog enable kept set so the digital path must win
	task t_digital;
		for (int s = 0; s < 8; s++) begin
			wr(TSRMUX_OFF_TEST, {1'b1, s[2:0], 4'h1});
			test_src <= 7'h40 >> s;
			repeat (2) @(posedge aclk);
			chk("pin0", port_a_pin0, {s < 7, 1'b1});
			chk("ana", {analog_ctl.port_a_pin0_analog_connect, analog_ctl.adc_analog_connect}, 2'b00);
			test_src <= ~(7'h40 >> s);
			repeat (2) @(posedge aclk);
			chk("pin0", port_a_pin0, 2'b01);
		end
	endtask : t_digital
	task t_analog;
		wr(TSRMUX_OFF_TEST, 8'h01);
		repeat (2) @(posedge aclk);
		chk("pin0 oe", port_a_pin0.oe, 1'b0);
		chk("ana", {analog_ctl.port_a_pin0_analog_connect, analog_ctl.adc_analog_connect}, 2'b11);
		rd(TSRMUX_OFF_STAT, 8'h05);
		wr(TSRMUX_OFF_TEST, 8'h00);
		repeat (2) @(posedge aclk);
		chk("pin0", port_a_pin0, gpio_pa0);
		chk("ana", analog_ctl.port_a_pin0_analog_connect, 1'b0);
		gpio_pa0 <= 2'b01;
		repeat (2) @(posedge aclk);
		chk("pin0", port_a_pin0, 2'b01);
		gpio_pa0 <= 2'b10;
	endtask : t_analog
	task t_fields;
		wr(TSRMUX_OFF_TEST, 8'h7E);
		rd(TSRMUX_OFF_TEST, 8'h7A);
		chk("uvlo park", {analog_ctl.gate_uvlo_level_select, analog_ctl.error_amp_park}, 2'b11);
		wr(TSRMUX_OFF_CONV, 8'hFF);
		rd(TSRMUX_OFF_CONV, 8'h7F);
		chk("chan", analog_ctl.analog_channel_field, 5'h1F);
		wr(TSRMUX_OFF_CONV, 8'h54);
		rd(TSRMUX_OFF_CONV, 8'h54);
		chk("chan", analog_ctl.analog_channel_field, 5'h15);
		wr(TSRMUX_OFF_TEST, 8'h00);
		repeat (2) @(posedge aclk);
		chk("uvlo park", {analog_ctl.gate_uvlo_level_select, analog_ctl.error_amp_park}, 2'b00);
	endtask : t_fields
	// Every role with both semi options; feedback bit follows semi
	task t_roles;
		logic [1:0] r;
		logic sm, ref_on, clk_out;
		for (int i = 0; i < 8; i++) begin
			r = i[2:1];
			sm = i[0];
			wr(TSRMUX_OFF_ROLE, {r, sm, 1'b1, sm, 3'h7});
			rd(TSRMUX_OFF_ROLE, {r, sm, 1'b0, sm, 3'h0});
			ref_on = (r == 2'b01) || (r == 2'b11 && !sm);
			clk_out = (r == 2'b01) || (r == 2'b11 && sm);
			chk("ref", analog_ctl.second_reference_dac_en, ref_on);
			chk("ext", sync_external, r == 2'b10);
			chk("rfb", analog_ctl.current_sense_output_pin_sel, sm);
			if (ref_on) chk("pb1 oe", port_b_pin1.oe, 1'b0);
			else chk("pb1", port_b_pin1, (r == 2'b11) ? 2'b11 : gpio_pb1);
			if (clk_out) begin
				chk("pa1", port_a_pin1, {sync_clock_output, 1'b1});
				// Toggle the exported clock so a constant cannot pass
				sync_clock_output <= 1'b0;
				repeat (2) @(posedge aclk);
				chk("pa1", port_a_pin1, 2'b01);
				sync_clock_output <= 1'b1;
			end else if (r != 2'b10) chk("pa1", port_a_pin1, gpio_pa1);
			else begin
				chk("pa1 oe", port_a_pin1.oe, 1'b0);
				port_a_pin1_i <= 1'b1;
				repeat (2) @(posedge aclk);
				chk("sync in", sync_clock_input, 1'b1);
				port_a_pin1_i <= 1'b0;
				repeat (2) @(posedge aclk);
				chk("sync in", sync_clock_input, 1'b0);
			end
		end
	endtask : t_roles
	// Main sequence
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 4'h0;
		s_axi_araddr = 4'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		test_src = '0;
		gpio_pa0 = 2'b10;
		gpio_pa1 = 2'b01;
		gpio_pb1 = 2'b10;
		sync_clock_output = 1'b1;
		port_a_pin1_i = 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_digital;
		t_analog;
		t_fields;
		t_roles;
		complete_run;
	end
endmodule : test_tsrmux_top

// *** dv/tsrmux_assertions.sv ***
// Port-level checks of the test signal and role mux control
`timescale 1ns/1ps
module tsrmux_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic port_a_pin1_i,
	input wire tsrmux_pkg::tsrmux_pin_t port_a_pin0,
	input wire tsrmux_pkg::tsrmux_pin_t port_b_pin1,
	input wire tsrmux_pkg::tsrmux_analog_t analog_ctl,
	input wire logic sync_clock_input,
	input wire logic sync_external
);
	import tsrmux_pkg::*;
	// ----------------------------------------
	// Checks, all in the single clock domain
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	r_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
	// Past value only trusted once slave role held for two edges
	sync_copy_a: assert property (sync_external && $past(sync_external) |->
		sync_clock_input == $past(port_a_pin1_i)) else $error("sync input not copied");
	sync_idle_a: assert property (!sync_external |-> !sync_clock_input) else $error("sync input leaks");
	ref_role_a: assert property (sync_external |-> !analog_ctl.second_reference_dac_en)
		else $error("reference on in slave role");
	ref_pin_a: assert property (analog_ctl.second_reference_dac_en |-> !port_b_pin1.oe)
		else $error("pb1 driven with reference");
	ana_pin_a: assert property (analog_ctl.port_a_pin0_analog_connect |-> !port_a_pin0.oe)
		else $error("pin0 driven with analog");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (sync_external && $past(sync_external));
	cover property (analog_ctl.second_reference_dac_en);
endmodule : tsrmux_assertions

bind tsrmux_top tsrmux_assertions chk (
	.aclk(aclk),
	.aresetn(aresetn),
	.s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.port_a_pin1_i(port_a_pin1_i),
	.port_a_pin0(port_a_pin0),
	.port_b_pin1(port_b_pin1),
	.analog_ctl(analog_ctl),
	.sync_clock_input(sync_clock_input),
	.sync_external(sync_external)
);

// *** hw/tsrmux_pkg.sv ***
// Package: register map, field layout, resets and types of the test/role mux control
package tsrmux_pkg;

	// Register byte addresses (offsets not printed; chosen here)
	localparam logic [3:0] TSRMUX_OFF_TEST = 4'h0;
	localparam logic [3:0] TSRMUX_OFF_ROLE = 4'h4;
	localparam logic [3:0] TSRMUX_OFF_CONV = 4'h8;
	localparam logic [3:0] TSRMUX_OFF_STAT = 4'hC;

	// Reset values
	localparam logic [7:0] TSRMUX_TEST_RESET = 8'h00;
	localparam logic [7:0] TSRMUX_ROLE_RESET = 8'h00;
	localparam logic [7:0] TSRMUX_CONV_RESET = 8'h00;

	// Writable bits of each register
	localparam logic [7:0] TSRMUX_TEST_MASK = 8'hFB;
	localparam logic [7:0] TSRMUX_ROLE_MASK = 8'hE8;
	localparam logic [7:0] TSRMUX_CONV_MASK = 8'h7F;

	// Field positions, test control
	localparam int TSRMUX_DIG_EN_BIT = 7;
	localparam int TSRMUX_DSEL_LSB = 4;
	localparam int TSRMUX_UVLO_BIT = 3;
	localparam int TSRMUX_EAPARK_BIT = 1;
	localparam int TSRMUX_ANA_EN_BIT = 0;
	// Field positions, role register
	localparam int TSRMUX_ROLE_LSB = 6;
	localparam int TSRMUX_RFB_BIT = 5;
	localparam int TSRMUX_SEMI_BIT = 3;
	// Field position, converter control
	localparam int TSRMUX_CHS_LSB = 2;

	// AXI responses
	localparam logic [1:0] TSRMUX_RESP_OKAY = 2'h0;
	localparam logic [1:0] TSRMUX_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TSRMUX_STANDALONE = 2'b00,
		TSRMUX_MASTER = 2'b01,
		TSRMUX_SLAVE = 2'b10,
		TSRMUX_SEMI = 2'b11
	} tsrmux_role_t;

	typedef enum logic [2:0] {
		TSRMUX_DSEL_COMP = 3'b000,
		TSRMUX_DSEL_PWML = 3'b001,
		TSRMUX_DSEL_PWM = 3'b010,
		TSRMUX_DSEL_TMR = 3'b011,
		TSRMUX_DSEL_OV = 3'b100,
		TSRMUX_DSEL_SWF = 3'b101,
		TSRMUX_DSEL_ONESHOT = 3'b110,
		TSRMUX_DSEL_NONE = 3'b111
	} tsrmux_dsel_t;

	// Internal digital test sources
	typedef struct packed {
		logic desat_comparator_out;
		logic pwm_after_monostable;
		logic pwm_oscillator;
		logic timer_match_flag;
		logic overvoltage_comparator_out;
		logic switching_freq_out;
		logic secondary_pulse_oneshot;
	} tsrmux_test_src_t;

	// One pin: output, enable
	typedef struct packed {
		logic o;
		logic oe;
	} tsrmux_pin_t;

	// Analog steering controls
	typedef struct packed {
		logic port_a_pin0_analog_connect;
		logic adc_analog_connect;
		logic [4:0] analog_channel_field;
		logic gate_uvlo_level_select;
		logic error_amp_park;
		logic current_sense_output_pin_sel;
		logic second_reference_dac_en;
	} tsrmux_analog_t;

endpackage : tsrmux_pkg

// *** hw/tsrmux_regs.sv ***
// Byte register bank with per-register write masks
`timescale 1ns/1ps
module tsrmux_regs #(
	parameter int NREG = 3
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] rd_idx,
	input wire logic [7:0] masks [NREG],
	input wire logic [7:0] resets [NREG],
	output logic [7:0] rd_data,
	output logic [7:0] q [NREG]
);
	// Storage; masked bits never take a one
	always_ff @(posedge aclk) begin
		for (int i = 0; i < NREG; i++) begin
			if (!aresetn) begin
				q[i] <= resets[i];
			end else if (wr_en && wr_idx == i[1:0]) begin
				q[i] <= wr_data & masks[i];
			end
		end
	end

	// Registered read port
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_data <= 8'h00;
		end else if (rd_idx < NREG[1:0]) begin
			rd_data <= q[rd_idx];
		end else begin
			rd_data <= 8'h00;
		end
	end
endmodule : tsrmux_regs

// *** hw/tsrmux_top.sv ***
// Test signal and system role pin mux control with AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Digital enable drives pin0 from test mux
// - Digital path wins over analog on pin0
// - Analog only: test signals reach converter input
// - Analog enable bit0 connects analog mux to pin0
// - Analog channel chosen by converter control field
// - Three-bit select picks digital source; 111 none
// - UVLO select resets low; set picks higher
// - Park resets zero; set parks amplifier low
// - Role 00: stand-alone, no reference, internal sync
// - Role 01: reference out, sync clock out
// - Role 10: sync taken from clock input
// - Role 11: semi bit picks reference or clock
// - Feedback bit steers sense amplifier to pin
// - Role bits 4,2..0 ignore writes, read zero
// - Channel field sits in converter bits 6..2
module tsrmux_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire tsrmux_pkg::tsrmux_test_src_t test_src,
	input wire tsrmux_pkg::tsrmux_pin_t gpio_pa0,
	input wire tsrmux_pkg::tsrmux_pin_t gpio_pa1,
	input wire tsrmux_pkg::tsrmux_pin_t gpio_pb1,
	input wire logic sync_clock_output,
	input wire logic port_a_pin1_i,
	output tsrmux_pkg::tsrmux_pin_t port_a_pin0,
	output tsrmux_pkg::tsrmux_pin_t port_a_pin1,
	output tsrmux_pkg::tsrmux_pin_t port_b_pin1,
	output tsrmux_pkg::tsrmux_analog_t analog_ctl,
	output logic sync_clock_input,
	output logic sync_external
);
	import tsrmux_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte address to register index; 3 means status register or unmapped
	function automatic logic [1:0] addr_idx(input logic [3:0] a);
		case (a)
			TSRMUX_OFF_TEST: addr_idx = 2'd0;
			TSRMUX_OFF_ROLE: addr_idx = 2'd1;
			TSRMUX_OFF_CONV: addr_idx = 2'd2;
			default: addr_idx = 2'd3;
		endcase
	endfunction : addr_idx

	function automatic logic mapped(input logic [3:0] a);
		mapped = (a == TSRMUX_OFF_TEST) || (a == TSRMUX_OFF_ROLE) ||
			(a == TSRMUX_OFF_CONV) || (a == TSRMUX_OFF_STAT);
	endfunction : mapped

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic aw_held;
	logic w_held;
	logic [3:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane;
	logic wr_fire;
	logic [7:0] masks [3];
	logic [7:0] resets [3];
	logic [7:0] q [3];
	logic [7:0] bank_rd;
	logic rd_pend;
	logic rd_stat;
	logic rd_bad;
	logic [1:0] rd_idx_q;

	assign masks[0] = TSRMUX_TEST_MASK;
	assign masks[1] = TSRMUX_ROLE_MASK;
	assign masks[2] = TSRMUX_CONV_MASK;
	assign resets[0] = TSRMUX_TEST_RESET;
	assign resets[1] = TSRMUX_ROLE_RESET;
	assign resets[2] = TSRMUX_CONV_RESET;

	// Commit once address and data both arrived and no response is pending
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	// Address and data latch independently, in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 4'h0;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane <= s_axi_wstrb[0];
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	// Response; unmapped address answers SLVERR, status register is read-only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= TSRMUX_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_addr) ? TSRMUX_RESP_OKAY : TSRMUX_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register bank
	// ----------------------------------------
	// Only byte lane 0 holds data; other lanes ignored
	tsrmux_regs #(
		.NREG(3)
	) u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(wr_fire && w_lane),
		.wr_idx(addr_idx(aw_addr)),
		.wr_data(w_byte),
		.rd_idx(addr_idx(s_axi_araddr)),
		.masks(masks),
		.resets(resets),
		.rd_data(bank_rd),
		.q(q)
	);

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	// Bank read data is registered on the acceptance edge, so rvalid follows one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			rd_pend <= 1'b0;
			rd_stat <= 1'b0;
			rd_bad <= 1'b0;
			rd_idx_q <= 2'd0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= TSRMUX_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !rd_pend && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				rd_pend <= 1'b1;
				rd_stat <= s_axi_araddr == TSRMUX_OFF_STAT;
				rd_bad <= !mapped(s_axi_araddr);
				rd_idx_q <= addr_idx(s_axi_araddr);
			end else if (rd_pend) begin
				rd_pend <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= rd_bad ? TSRMUX_RESP_SLVERR : TSRMUX_RESP_OKAY;
				// Status shows the live pin ownership
				s_axi_rdata <= rd_stat ? {26'h0, sync_external, sync_clock_input, port_b_pin1.oe,
					port_a_pin1.oe, port_a_pin0.oe, analog_ctl.adc_analog_connect}
					: {24'h0, bank_rd};
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	logic dig_en;
	logic ana_en;
	tsrmux_dsel_t dsel;
	tsrmux_role_t role;
	logic semi_opt;
	logic dig_val;

	assign dig_en = q[0][TSRMUX_DIG_EN_BIT];
	assign ana_en = q[0][TSRMUX_ANA_EN_BIT];
	assign dsel = tsrmux_dsel_t'(q[0][TSRMUX_DSEL_LSB +: 3]);
	assign role = tsrmux_role_t'(q[1][TSRMUX_ROLE_LSB +: 2]);
	assign semi_opt = q[1][TSRMUX_SEMI_BIT];

	// Digital test source select; unimplemented code drives low
	always_comb begin
		case (dsel)
			TSRMUX_DSEL_COMP: dig_val = test_src.desat_comparator_out;
			TSRMUX_DSEL_PWML: dig_val = test_src.pwm_after_monostable;
			TSRMUX_DSEL_PWM: dig_val = test_src.pwm_oscillator;
			TSRMUX_DSEL_TMR: dig_val = test_src.timer_match_flag;
			TSRMUX_DSEL_OV: dig_val = test_src.overvoltage_comparator_out;
			TSRMUX_DSEL_SWF: dig_val = test_src.switching_freq_out;
			TSRMUX_DSEL_ONESHOT: dig_val = test_src.secondary_pulse_oneshot;
			default: begin
				dig_val = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Pin 0: test outputs over GPIO
	// ----------------------------------------
	// Analog drive is not a digital level, so the digital driver is released
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_pin0 <= '0;
		end else if (dig_en) begin
			port_a_pin0.o <= dig_val;
			port_a_pin0.oe <= 1'b1;
		end else if (ana_en) begin
			port_a_pin0 <= '0;
		end else begin
			port_a_pin0 <= gpio_pa0;
		end
	end

	// ----------------------------------------
	// Analog controls
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_ctl <= '0;
		end else begin
			analog_ctl.port_a_pin0_analog_connect <= ana_en && !dig_en;
			analog_ctl.adc_analog_connect <= ana_en && !dig_en;
			analog_ctl.analog_channel_field <= q[2][TSRMUX_CHS_LSB +: 5];
			analog_ctl.gate_uvlo_level_select <= q[0][TSRMUX_UVLO_BIT];
			analog_ctl.error_amp_park <= q[0][TSRMUX_EAPARK_BIT];
			analog_ctl.current_sense_output_pin_sel <= q[1][TSRMUX_RFB_BIT];
			analog_ctl.second_reference_dac_en <= (role == TSRMUX_MASTER) ||
				(role == TSRMUX_SEMI && !semi_opt);
		end
	end
	// ----------------------------------------
	// Role pins
	// ----------------------------------------
	// Reference pin released to the analog buffer: digital driver off
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_pin1 <= '0;
			port_b_pin1 <= '0;
			sync_clock_input <= 1'b0;
			sync_external <= 1'b0;
		end else begin
			port_a_pin1 <= gpio_pa1;
			port_b_pin1 <= gpio_pb1;
			sync_external <= 1'b0;
			sync_clock_input <= 1'b0;
			case (role)
				TSRMUX_MASTER: begin
					port_b_pin1 <= '0;
					port_a_pin1.o <= sync_clock_output;
					port_a_pin1.oe <= 1'b1;
				end
				TSRMUX_SLAVE: begin
					port_a_pin1 <= '0;
					sync_clock_input <= port_a_pin1_i;
					sync_external <= 1'b1;
				end
				TSRMUX_SEMI: begin
					if (semi_opt) begin
						port_b_pin1.oe <= 1'b1;
						port_a_pin1.o <= sync_clock_output;
						port_a_pin1.oe <= 1'b1;
					end else begin
						port_b_pin1 <= '0;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule : tsrmux_top
